// File: core/epc_pkg.sv
package epc_pkg;

   // ****************************************************************
   // Register map and field layout.
   // ****************************************************************
   localparam logic [7:0] CTRL_ADDR = 8'h97;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'hb0;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'hb1;
   localparam logic [7:0] BUF_ADDR_ADDR = 8'hb2;
   localparam logic [7:0] BUF_DATA_ADDR = 8'hb3;
   localparam logic [7:0] MODE_ADDR = 8'hb4;
   localparam logic [7:0] PROGRESS_ADDR = 8'hb5;
   localparam int INHIBIT_BIT = 7;
   localparam int DONE_IE_BIT = 3;
   localparam int DONE_BIT = 2;
   localparam int CROSS_BIT = 1;
   localparam int START_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_RW_MASK = 8'h88;

   // ****************************************************************
   // Interrupt status bit positions.
   // ****************************************************************
   localparam int EV_DONE = 0;
   localparam int EV_CROSS = 1;
   localparam int EV_REFUSED = 2;
   localparam logic [2:0] EV_RESET = 3'h0;

   // ****************************************************************
   // Array geometry and cell timing.
   // ****************************************************************
   localparam int EE_BYTES = 256;
   localparam int PAGE_BYTES = 16;
   localparam int CELL_TIME_US = 2;
   localparam int CLK_MHZ = 125;
   localparam int CELL_CYCLES = CELL_TIME_US * CLK_MHZ;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } epc_bus_req_t;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } epc_mem_wr_t;

endpackage : epc_pkg

// File: core/epc_array.sv
`timescale 1ns/1ps

// ****************************************************************
// Byte array model of the data EEPROM cells, registered read.
// ****************************************************************
module epc_array #(
   parameter int DEPTH = 256
) (
   // Clock.
   input wire logic ref_clk,
   // Write port.
   input wire epc_pkg::epc_mem_wr_t wr,
   // Read port.
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data
);

   initial begin
      if (DEPTH != 256) begin
         $error("epc_array: depth must be 256.");
      end
   end

   logic [7:0] mem [DEPTH];

   // Cells keep no reset; they are nonvolatile in the real part.
   always_ff @(posedge ref_clk) begin
      if (wr.we) begin
         mem[wr.addr] <= wr.data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : epc_array

// File: core/epc_ctrl.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

// Summary of operation
// - Inhibit bit set refuses every program cycle; bit resets to zero.
// - Done interrupt needs local enable and global enable both high.
// - Finishing a program cycle sets the done flag.
// - Only hardware sets done flag; software zero write clears it.
// - Setting start bit clears done flag automatically.
// - Buffer writes spanning two pages set the cross page flag.
// - Start requests are ignored while cross page flag is set.
// - Software cannot set the cross page flag.
// - Software fills buffer, then start bit begins the program cycle.
// - Start is rejected when buffer has no new data.
// - Hardware clears start bit at finish; software zero ignored.
// - 256 byte array, page or single byte programming supported.
module epc_ctrl #(
   parameter int PAGE_BYTES = epc_pkg::PAGE_BYTES,
   parameter int CELL_CYCLES = epc_pkg::CELL_CYCLES
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Interrupt.
   input wire logic global_irq_enable,
   output logic program_done_irq,
   output logic irq
);

   // ****************************************************************
   // Parameter checks.
   // ****************************************************************
   // The cell counter is twelve bits wide and the page offset must tile the
   // 256 byte array, so both limits below come from the logic itself.
   initial begin
      if (PAGE_BYTES < 1 || PAGE_BYTES > 256 || (256 % PAGE_BYTES) != 0) begin
         $error("epc_ctrl: page size must divide 256.");
      end
      if (CELL_CYCLES < 1 || CELL_CYCLES > 4096) begin
         $error("epc_ctrl: cell cycles out of range.");
      end
   end

   // ****************************************************************
   // Register map and sequencing overview.
   // ****************************************************************
   // The control register carries inhibit, done enable, done, crossing and start.
   // Status holds the refused, crossing and done events; a one written clears a bit.
   // The mask register shares the status layout and gates the level interrupt.
   // Software loads the pointer, then writes bytes that post-increment it.
   // Reading the data address returns the array byte at the pointer.
   // Mode bit zero selects single byte programming; progress shows the byte index.
   // A program cycle spends one write cycle and then the cell time on each byte.
   // Page mode walks every offset of the captured page but writes only valid bytes.
   // Buffer, pointer and mode writes are dropped while a cycle runs, so software
   // cannot disturb the bytes that are being programmed.

   localparam int PB = $clog2(PAGE_BYTES) > 0 ? $clog2(PAGE_BYTES) : 1;

   typedef enum logic [1:0] {
      EPC_IDLE,
      EPC_WRITE,
      EPC_WAIT
   } epc_state_t;

   // ****************************************************************
   // Registers.
   // ****************************************************************
   epc_state_t state_r, state_nxt;
   logic inhibit_r, done_ie_r, done_r, cross_r, start_r;
   logic [2:0] ev_stat_r;
   logic [2:0] ev_mask_r;
   logic [7:0] buf_ptr_r;
   logic [7:0] buf_data [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] buf_valid_r;
   logic [7:0] page_r;
   logic page_set_r;
   logic single_byte_r;
   logic [7:0] prog_idx_r;
   logic [11:0] cell_cnt_r;
   logic [7:0] buf_ptr_nxt;
   logic [7:0] reg_rdata_r;
   logic [7:0] arr_rdata;
   epc_pkg::epc_mem_wr_t mem_wr;

   // ****************************************************************
   // Address decode and write effects.
   // ****************************************************************
   wire wr_ctrl = reg_wr && (reg_addr == epc_pkg::CTRL_ADDR);
   wire wr_stat = reg_wr && (reg_addr == epc_pkg::IRQ_STAT_ADDR);
   wire wr_mask = reg_wr && (reg_addr == epc_pkg::IRQ_MASK_ADDR);
   wire wr_ptr = reg_wr && (reg_addr == epc_pkg::BUF_ADDR_ADDR);
   wire wr_data = reg_wr && (reg_addr == epc_pkg::BUF_DATA_ADDR);
   wire wr_mode = reg_wr && (reg_addr == epc_pkg::MODE_ADDR);
   wire rd_arr = reg_rd && (reg_addr == epc_pkg::BUF_DATA_ADDR);
   wire busy = (state_r != EPC_IDLE);
   wire buf_any = |buf_valid_r;
   wire start_req = wr_ctrl && reg_wdata[epc_pkg::START_BIT];
   // Start is taken only with fresh data, no cross page and no inhibit.
   wire start_ok = start_req && !busy && buf_any
      && !cross_r
      && !inhibit_r;
   // A start that lands while a cycle runs is neither taken nor counted as refused.
   wire start_refused = start_req && !busy && !start_ok;
   wire [PB-1:0] ptr_off = buf_ptr_r[PB-1:0];
   // Single mode programs the byte written last; the pointer has moved past it.
   // Rewriting the pointer after the data moves that choice as well.
   wire [PB-1:0] last_off = ptr_off - PB'(1);
   wire [7:0] ptr_page = buf_ptr_r & ~8'(PAGE_BYTES - 1);
   // A byte that lands on another page than the first one is a crossing.
   wire cross_hit = wr_data && !busy && page_set_r && (ptr_page != page_r);
   wire [PB-1:0] prog_off = prog_idx_r[PB-1:0];
   wire cell_end = (cell_cnt_r == 12'(CELL_CYCLES - 1));
   wire last_byte = (prog_idx_r == 8'(PAGE_BYTES - 1));
   wire finish = (state_r == EPC_WAIT) && cell_end && (last_byte || single_byte_r);
   // Status bit order follows the package: done, crossing, refused.
   wire [2:0] ev_set = {start_refused, cross_hit, finish};
   wire [7:0] ctrl_view = {inhibit_r, 3'h0, done_ie_r, done_r, cross_r, start_r};

   // Each buffered byte goes to the array in the write state.
   assign mem_wr.we = (state_r == EPC_WRITE) && buf_valid_r[prog_off];
   assign mem_wr.addr = page_r | prog_idx_r;
   assign mem_wr.data = buf_data[prog_off];

   // ****************************************************************
   // Program sequencer.
   // ****************************************************************
   // A byte takes one write cycle and then CELL_CYCLES wait cycles, so a full
   // page holds the sequencer for PAGE_BYTES times that span.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         EPC_IDLE: begin
            if (start_ok) begin
               state_nxt = EPC_WRITE;
            end
         end
         EPC_WRITE: begin
            state_nxt = EPC_WAIT;
         end
         EPC_WAIT: begin
            if (cell_end) begin
               state_nxt = (last_byte || single_byte_r) ? EPC_IDLE : EPC_WRITE;
            end
         end
         default: begin
            state_nxt = EPC_IDLE;
         end
      endcase
   end

   // State register; an unknown encoding falls back to idle through the default.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_r <= EPC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Cell timer and byte walker; single mode programs the byte one below the pointer, the one written last.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cell_cnt_r <= 12'h000;
         prog_idx_r <= 8'h00;
      end else if (start_ok) begin
         cell_cnt_r <= 12'h000;
         prog_idx_r <= single_byte_r ? 8'(last_off) : 8'h00;
      end else if (state_r == EPC_WAIT) begin
         cell_cnt_r <= cell_end ? 12'h000 : cell_cnt_r + 12'h001;
         if (cell_end && !last_byte && !single_byte_r) begin
            prog_idx_r <= prog_idx_r + 8'h01;
         end
      end
   end

   // ****************************************************************
   // Control register.
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         inhibit_r <= 1'b0;
         done_ie_r <= 1'b0;
         done_r <= 1'b0;
         cross_r <= 1'b0;
         start_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            inhibit_r <= reg_wdata[epc_pkg::INHIBIT_BIT];
            done_ie_r <= reg_wdata[epc_pkg::DONE_IE_BIT];
         end
         // Finish wins over any clear in the same cycle.
         if (finish) begin
            done_r <= 1'b1;
         end else if (start_ok) begin
            done_r <= 1'b0;
         end else if (wr_ctrl && !reg_wdata[epc_pkg::DONE_BIT]) begin
            done_r <= 1'b0;
         end else if (wr_stat && reg_wdata[epc_pkg::EV_DONE]) begin
            done_r <= 1'b0;
         end
         // After clearing the crossing, software leaves a few idle instructions
         // before touching the array; the block itself needs no recovery time.
         // Software may only clear the crossing; a one is ignored.
         if (cross_hit) begin
            cross_r <= 1'b1;
         end else if (wr_ctrl && !reg_wdata[epc_pkg::CROSS_BIT]) begin
            cross_r <= 1'b0;
         end
         // Start clears only on finish; software zero has no effect.
         if (finish) begin
            start_r <= 1'b0;
         end else if (start_ok) begin
            start_r <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Write buffer.
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         buf_ptr_r <= 8'h00;
         buf_valid_r <= '0;
         page_r <= 8'h00;
         page_set_r <= 1'b0;
         single_byte_r <= 1'b0;
      end else begin
         if (wr_mode && !busy) begin
            single_byte_r <= reg_wdata[0];
         end
         if (wr_ptr && !busy) begin
            buf_ptr_r <= reg_wdata;
         end else if (wr_data && !busy) begin
            buf_ptr_r <= buf_ptr_r + 8'h01;
         end
         // A crossing byte is dropped rather than buffered, so the page held in
         // the buffer stays whole and can still be programmed once the flag clears.
         // The buffer is consumed by the cycle it feeds.
         if (finish) begin
            buf_valid_r <= '0;
            page_set_r <= 1'b0;
         end else if (wr_data && !busy && !cross_hit) begin
            buf_valid_r[ptr_off] <= 1'b1;
            if (!page_set_r) begin
               page_r <= ptr_page;
               page_set_r <= 1'b1;
            end
         end
      end
   end

   // Buffer data carry no reset; valid bits guard them.
   always_ff @(posedge ref_clk) begin
      if (wr_data && !busy && !cross_hit) begin
         buf_data[ptr_off] <= reg_wdata;
      end
   end

   // ****************************************************************
   // Interrupt status and mask.
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ev_stat_r <= epc_pkg::EV_RESET;
         ev_mask_r <= epc_pkg::EV_RESET;
      end else begin
         // Set beats a write-one clear in the same cycle.
         ev_stat_r <= ev_set | (ev_stat_r & ~(wr_stat ? reg_wdata[2:0] : 3'h0));
         if (wr_mask) begin
            ev_mask_r <= reg_wdata[2:0];
         end
      end
   end

   // The level interrupt serves polling software through status and mask, while
   // the done request follows the control register's own enable and the core's
   // global enable, as the core's interrupt controller expects.
   // Outputs leave from flops; local and global enable gate the request.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         program_done_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         program_done_irq <= done_r && done_ie_r && global_irq_enable;
         irq <= |(ev_stat_r & ev_mask_r);
      end
   end

   // ****************************************************************
   // Array and read data.
   // ****************************************************************
   // The array is addressed with the pointer's next value, so its registered
   // data already hold the byte at the pointer in the cycle of a read strobe.
   // A read during a program cycle may show a byte before it is rewritten.
   assign buf_ptr_nxt = (wr_ptr && !busy) ? reg_wdata
      : (wr_data && !busy) ? buf_ptr_r + 8'h01
      : buf_ptr_r;

   // The array is the only instance; its read data leave a register inside it.
   epc_array #(
      .DEPTH(epc_pkg::EE_BYTES)
   ) u_array (
      .ref_clk(ref_clk),
      .wr(mem_wr),
      .rd_addr(buf_ptr_nxt),
      .rd_data(arr_rdata)
   );

   logic [7:0] rd_mux;

   // Unmapped addresses read zero.
   always_comb begin
      case (reg_addr)
         epc_pkg::CTRL_ADDR: rd_mux = ctrl_view;
         epc_pkg::IRQ_STAT_ADDR: rd_mux = {5'h00, ev_stat_r};
         epc_pkg::IRQ_MASK_ADDR: rd_mux = {5'h00, ev_mask_r};
         epc_pkg::BUF_ADDR_ADDR: rd_mux = buf_ptr_r;
         epc_pkg::MODE_ADDR: rd_mux = {7'h00, single_byte_r};
         epc_pkg::PROGRESS_ADDR: rd_mux = prog_idx_r;
         default: rd_mux = 8'h00;
      endcase
   end

   // Array reads bypass the register mux; the array data are already registered.
   wire [7:0] rd_sel = rd_arr ? arr_rdata : rd_mux;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         reg_rdata_r <= 8'h00;
      end else begin
         reg_rdata_r <= reg_rd ? rd_sel : 8'h00;
      end
   end

   // The port is the answer flop itself, so no logic sits behind the register.
   assign reg_rdata = reg_rdata_r;

endmodule : epc_ctrl

// File: tb/epc_ctrl_chk.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker for the program control block.
// ****************************************************************
module epc_ctrl_chk #(
   parameter int PAGE_BYTES = 16,
   parameter int CELL_CYCLES = 4
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Interrupt.
   input wire logic global_irq_enable,
   input wire logic program_done_irq,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Decodes of control accesses.
   wire ctrl_wr = reg_wr && reg_addr == epc_pkg::CTRL_ADDR;
   wire ctrl_rd = reg_rd && reg_addr == epc_pkg::CTRL_ADDR;
   logic ie_r;
   logic inh_r;
   logic mask_r;

   // Shadows of software bits only; hardware flags cannot be mirrored from ports.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ie_r <= 1'h0;
         inh_r <= 1'h0;
         mask_r <= 1'h0;
      end else if (ctrl_wr) begin
         ie_r <= reg_wdata[3];
         inh_r <= reg_wdata[7];
      end else if (reg_wr && reg_addr == epc_pkg::IRQ_MASK_ADDR) begin
         mask_r <= |reg_wdata[2:0];
      end
   end

   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   AST_RSVD_ZERO: assert property ($past(ctrl_rd) |-> reg_rdata[6:4] == 3'h0)
      else $error("reserved control bits not zero");
   AST_UNMAPPED: assert property ($past(reg_rd && reg_addr == 8'h00) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_DONE_GATE: assert property (program_done_irq |->
      $past(global_irq_enable) && $past(ie_r))
      else $error("done interrupt without both enables");
   AST_READBACK: assert property (ctrl_wr ##2 ctrl_rd |=>
      (reg_rdata & 8'h88) == ($past(reg_wdata, 3) & 8'h88))
      else $error("inhibit or enable bit readback wrong");
   AST_INHIBIT: assert property (ctrl_wr && reg_wdata[7] && reg_wdata[0] && inh_r
      ##2 ctrl_rd |=> !reg_rdata[0])
      else $error("start accepted while inhibited");
   AST_IRQ_MASK: assert property (irq |-> $past(mask_r))
      else $error("interrupt with all events masked");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(reg_wr, 2))
      else $error("interrupt dropped without a register write");

   // Main scenarios reached.
   COV_START: cover property (ctrl_wr && reg_wdata[0]);
   COV_DONE: cover property ($rose(program_done_irq));
   COV_IRQ: cover property ($rose(irq));
endmodule : epc_ctrl_chk

bind epc_ctrl epc_ctrl_chk #(.PAGE_BYTES(PAGE_BYTES), .CELL_CYCLES(CELL_CYCLES)) i_epc_ctrl_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .global_irq_enable(global_irq_enable), .program_done_irq(program_done_irq), .irq(irq)
);

// File: tb/tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Directed bench for the program control block.
// ****************************************************************
module tb;
   localparam logic [7:0] CTL = epc_pkg::CTRL_ADDR;
   localparam logic [7:0] STA = epc_pkg::IRQ_STAT_ADDR;
   localparam logic [7:0] PTR = epc_pkg::BUF_ADDR_ADDR;
   localparam logic [7:0] DAT = epc_pkg::BUF_DATA_ADDR;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic global_irq_enable = 1'h0;
   logic [7:0] reg_rdata;
   logic program_done_irq;
   logic irq;
   int n_mismatch = 0;
   int n_checks = 0;

   // Clock; the cell time is long enough that busy can be seen by a read.
   always #4 ref_clk = ~ref_clk;
   epc_ctrl #(.PAGE_BYTES(16), .CELL_CYCLES(40)) i_epc_ctrl (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .global_irq_enable(global_irq_enable), .program_done_irq(program_done_irq), .irq(irq)
   );

   // ****************************************************************
   // Bus and compare tasks.
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask : wr

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // The answer is sampled just after the edge that closes the read cycle.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, exp, m);
   endtask : rd

   // Bounded poll; a full page of cell times fits well inside the limit.
   task automatic wait_done();
      int i;
      for (i = 0; i < 1000 && i_done() !== 1'h1; i++) @(posedge ref_clk);
      chk({7'h00, program_done_irq}, 8'h01, "program finished");
   endtask : wait_done

   function automatic logic i_done();
      return program_done_irq;
   endfunction : i_done

   task automatic outs(input logic [1:0] exp, input string m);
      repeat (3) @(posedge ref_clk);
      chk({6'h00, program_done_irq, irq}, {6'h00, exp}, m);
   endtask : outs

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_basic();
      rd(CTL, 8'h00, "ctrl reset");
      rd(8'h00, 8'h00, "unmapped");
      wr(CTL, 8'h7a);
      rd(CTL, 8'h08, "reserved and cross write");
      wr(CTL, 8'h01);
      rd(CTL, 8'h00, "start with empty buffer");
      rd(STA, 8'h04, "refused event");
      wr(STA, 8'h07);
      rd(STA, 8'h00, "status clear");
   endtask : t_basic

   task automatic t_inhibit();
      wr(PTR, 8'h10);
      wr(DAT, 8'ha5);
      wr(CTL, 8'h80);
      wr(CTL, 8'h81);
      rd(CTL, 8'h80, "start while inhibited");
      wr(CTL, 8'h00);
      wr(STA, 8'h07);
   endtask : t_inhibit

   task automatic t_program();
      wr(epc_pkg::IRQ_MASK_ADDR, 8'h01);
      global_irq_enable <= 1'h1;
      wr(CTL, 8'h09);
      rd(CTL, 8'h09, "start taken");
      wr(CTL, 8'h08);
      rd(CTL, 8'h09, "start zero write");
      wait_done();
      rd(CTL, 8'h0c, "finish");
      outs(2'h3, "irq after finish");
      global_irq_enable <= 1'h0;
      outs(2'h1, "global enable off");
      global_irq_enable <= 1'h1;
      wr(PTR, 8'h10);
      rd(DAT, 8'ha5, "array byte");
      wr(PTR, 8'h12);
      wr(DAT, 8'h3c);
      wr(CTL, 8'h0d);
      rd(CTL, 8'h09, "start clears done");
      wait_done();
      wr(CTL, 8'h08);
      rd(CTL, 8'h08, "software clears done");
      wr(STA, 8'h07);
      outs(2'h0, "irq cleared");
   endtask : t_program

   task automatic t_cross();
      wr(PTR, 8'h20);
      wr(DAT, 8'h11);
      wr(PTR, 8'h35);
      wr(DAT, 8'h22);
      rd(CTL, 8'h0a, "cross flag");
      wr(CTL, 8'h0b);
      rd(CTL, 8'h0a, "start during cross");
      wr(CTL, 8'h08);
      repeat (4) @(posedge ref_clk);
      wr(CTL, 8'h09);
      rd(CTL, 8'h09, "start after cross cleared");
      wait_done();
   endtask : t_cross

   // One byte programmed alone lands at the address it was written through.
   task automatic t_single();
      wr(epc_pkg::MODE_ADDR, 8'h01);
      wr(PTR, 8'h47);
      wr(DAT, 8'h5a);
      wr(CTL, 8'h09);
      rd(CTL, 8'h09, "single start taken");
      wait_done();
      wr(epc_pkg::MODE_ADDR, 8'h00);
      wr(PTR, 8'h47);
      rd(DAT, 8'h5a, "single byte stored");
   endtask : t_single

   // ****************************************************************
   // Run control.
   // ****************************************************************
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence after a two-cycle reset.
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_basic();
      t_inhibit();
      t_program();
      t_cross();
      t_single();
      report_and_stop();
   end

   // Watchdog well beyond the few thousand cycles the run needs.
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb
